//--- bps_backup_power_switchover.v
// Supply switchover, sealing, failure flag, serial port gating and interrupt pin routing.
//
// What this block does
// - Normal entry to backup: below backup and trip.
// - Leave backup when either exit comparator holds; in low-power mode only above-backup.
// - Backup mode disables serial clock and data.
// - Other functions run unless disabled for backup.
// - Total power loss sets clock failure flag.
// - Low-power switching ignores trip threshold entirely.
// - Low-power bit selects mode, gates trip monitor.
// - Sealed: no backup until main first seen.
// - Writing seal bit returns to sealed state.
// - Pin one: interrupt or frequency output.
// - Pin two source: alarm or timer events.
// - Alarm flag readable, optionally on a pin.
// - Timer flag readable, optionally on pin two.
// - Pin two is open drain, low-only.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "bps_map.vh"
module bps_backup_power_switchover (
	core_clk,
	rst,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_readdata,
	avs_waitrequest,
	oscInputPin,
	cmpBelowBackup,
	cmpAboveBackup,
	cmpBelowTrip,
	cmpAboveTripHys,
	totalLossPowerUp,
	alarmEvent,
	timerEvent,
	sclIn,
	sdaDriveLow,
	sclGated,
	sdaOut,
	sdaOe,
	backupSel,
	backupDrawEn,
	tripMonitorEn,
	irqFreqOutPinOut,
	irqFreqOutPinOe,
	secondIrqPinOut,
	secondIrqPinOe,
	irq
);
	input  wire                   core_clk;
	input  wire                   rst;
	input  wire [`BPS_ADDR_W-1:0] avs_address;
	input  wire                   avs_read;
	input  wire                   avs_write;
	input  wire [31:0]            avs_writedata;
	output reg  [31:0]            avs_readdata;
	output wire                   avs_waitrequest;
	input  wire                   oscInputPin;
	input  wire                   cmpBelowBackup;
	input  wire                   cmpAboveBackup;
	input  wire                   cmpBelowTrip;
	input  wire                   cmpAboveTripHys;
	input  wire                   totalLossPowerUp;
	input  wire                   alarmEvent;
	input  wire                   timerEvent;
	input  wire                   sclIn;
	input  wire                   sdaDriveLow;
	output reg                    sclGated;
	output wire                   sdaOut;
	output reg                    sdaOe;
	output reg                    backupSel;
	output reg                    backupDrawEn;
	output reg                    tripMonitorEn;
	output wire                   irqFreqOutPinOut;
	output reg                    irqFreqOutPinOe;
	output wire                   secondIrqPinOut;
	output reg                    secondIrqPinOe;
	output wire                   irq;

	// Synchronised comparator and timebase levels.
	wire [4:0] cmpSync;
	wire       oscSync;
	wire       belowBackupS;
	wire       aboveBackupS;
	wire       belowTripS;
	wire       aboveTripS;
	wire       totalLossS;

	// Timebase edge and sampled comparator state.
	reg        oscPrev_r;
	wire       oscTick;
	reg  [3:0] cmpTb_r;
	reg        totalLossPrev_r;
	wire       totalLossRise;

	// Supply mode and seal state.
	reg        backup_r;
	reg        backupNxt;
	reg        sealed_r;
	reg        armed_r;
	wire       mainLost;
	wire       mainGood;
	wire       enterNormal;
	wire       enterLowPower;

	// Registers.
	reg  [`BPS_CTRL_W-1:0] ctrl_r;
	reg  [`BPS_ST_W-1:0]   status_r;
	reg  [`BPS_ST_W-1:0]   statusNxt;
	reg  [`BPS_ST_W-1:0]   mask_r;
	reg                    ack_r;
	reg  [31:0]            readNxt;
	wire                   busReq;
	wire                   wrTake;
	wire                   wrCtrl;
	wire                   wrStatus;
	wire                   wrMask;
	wire [`BPS_ST_W-1:0]   setEvents;
	wire [`BPS_ST_W-1:0]   clrBits;

	// Pin routing.
	wire       lowPowerSel;
	wire       pin1FreqSel;
	wire [1:0] pin2Src;
	wire       freqOffInBackup;
	wire       alarmOffInBackup;
	wire       alarmActive;
	wire       freqActive;
	wire       freqWave;
	reg        pin2Assert;
	wire       pin1Low;

	bps_sync #(
		.WIDTH   (5)
	) u_cmp_sync (
		.core_clk(core_clk),
		.rst     (rst),
		.asyncIn ({totalLossPowerUp, cmpAboveTripHys, cmpBelowTrip, cmpAboveBackup, cmpBelowBackup}),
		.syncOut (cmpSync)
	);

	// The timebase pin may carry a crystal signal or an external square wave; both look alike here.
	// Timebase level capture
	bps_sync #(
		.WIDTH   (1)
	) u_osc_sync (
		.core_clk(core_clk),
		.rst     (rst),
		.asyncIn (oscInputPin),
		.syncOut (oscSync)
	);

	assign belowBackupS = cmpSync[0];
	assign aboveBackupS = cmpSync[1];
	assign belowTripS   = cmpSync[2];
	assign aboveTripS   = cmpSync[3];
	assign totalLossS   = cmpSync[4];

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			oscPrev_r       <= 1'b0;
			totalLossPrev_r <= 1'b0;
		end else begin
			oscPrev_r       <= oscSync;
			totalLossPrev_r <= totalLossS;
		end
	end

	assign oscTick       = oscSync & ~oscPrev_r;
	assign totalLossRise = totalLossS & ~totalLossPrev_r;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmpTb_r <= 4'h0;
		end else if (oscTick) begin
			cmpTb_r <= {aboveTripS, belowTripS, aboveBackupS, belowBackupS};
		end
	end

	assign lowPowerSel      = ctrl_r[`BPS_CTRL_LOWPWR];
	assign pin1FreqSel      = ctrl_r[`BPS_CTRL_PIN1FUNC];
	assign pin2Src          = ctrl_r[`BPS_CTRL_PIN2SRC_HI:`BPS_CTRL_PIN2SRC_LO];
	assign freqOffInBackup  = ctrl_r[`BPS_CTRL_FOFFBAK];
	assign alarmOffInBackup = ctrl_r[`BPS_CTRL_AOFFBAK];

	assign enterNormal   = cmpTb_r[0] & cmpTb_r[2];
	assign enterLowPower = cmpTb_r[0];
	assign mainLost      = lowPowerSel ? enterLowPower : enterNormal;
	assign mainGood      = lowPowerSel ? cmpTb_r[1] : (cmpTb_r[1] | cmpTb_r[3]);

	always @* begin
		backupNxt = backup_r;
		if (!backup_r) begin
			if (mainLost && !sealed_r) begin
				backupNxt = 1'b1;
			end
		end else if (mainGood) begin
			backupNxt = 1'b0;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			backup_r <= 1'b0;
		end else if (oscTick) begin
			backup_r <= backupNxt;
		end
	end

	// Reset is the first main power-up, so the seal is armed to open at the first good supply.
	// Seal opens on main
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sealed_r <= 1'b1;
			armed_r  <= 1'b1;
		end else if (wrStatus && avs_writedata[`BPS_ST_SEAL]) begin
			sealed_r <= 1'b1;
			armed_r  <= 1'b0;
		end else if (oscTick && sealed_r) begin
			if (armed_r && mainGood) begin
				sealed_r <= 1'b0;
			end else if (mainLost) begin
				armed_r <= 1'b1;
			end
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			backupSel     <= 1'b0;
			backupDrawEn  <= 1'b0;
			tripMonitorEn <= 1'b1;
			sclGated      <= 1'b0;
			sdaOe         <= 1'b0;
		end else begin
			backupSel     <= backup_r;
			backupDrawEn  <= ~sealed_r;
			tripMonitorEn <= ~lowPowerSel | backup_r;
			sclGated      <= sclIn & ~backup_r;
			sdaOe         <= sdaDriveLow & ~backup_r;
		end
	end

	assign sdaOut = 1'b0;

	// Avalon-MM slave: every access is answered one cycle after it is raised.
	assign busReq          = avs_read | avs_write;
	assign avs_waitrequest = busReq & ~ack_r;
	assign wrTake          = avs_write & ack_r;
	assign wrCtrl          = wrTake & (avs_address == `BPS_OFS_CTRL);
	assign wrStatus        = wrTake & (avs_address == `BPS_OFS_STATUS);
	assign wrMask          = wrTake & (avs_address == `BPS_OFS_MASK);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= busReq & ~ack_r;
		end
	end

	always @* begin
		readNxt = 32'h00000000;
		case (avs_address)
			`BPS_OFS_CTRL:   readNxt[`BPS_CTRL_W-1:0] = ctrl_r;
			`BPS_OFS_STATUS: readNxt[`BPS_ST_W:0] = {sealed_r, status_r};
			`BPS_OFS_MASK:   readNxt[`BPS_ST_W-1:0] = mask_r;
			`BPS_OFS_STATE:  readNxt[3:0] = {~backup_r, armed_r, sealed_r, backup_r};
			default:         readNxt = 32'h00000000;
		endcase
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !ack_r) begin
			avs_readdata <= readNxt;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= `BPS_CTRL_RST;
			mask_r <= `BPS_MASK_RST;
		end else begin
			if (wrCtrl) begin
				ctrl_r <= avs_writedata[`BPS_CTRL_W-1:0];
			end
			if (wrMask) begin
				mask_r <= avs_writedata[`BPS_ST_W-1:0];
			end
		end
	end

	// Alarm capture stops in backup when disabled for it.
	// Backup disable gating
	assign alarmActive = ~(backup_r & alarmOffInBackup);
	assign freqActive  = ~(backup_r & freqOffInBackup);

	assign setEvents = {timerEvent, alarmEvent & alarmActive, backup_r & ~backupSel, totalLossRise};
	assign clrBits   = wrStatus ? avs_writedata[`BPS_ST_W-1:0] : {`BPS_ST_W{1'b0}};

	// A set in the same cycle as its clear wins.
	always @* begin
		statusNxt = (status_r & ~clrBits) | setEvents;
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			status_r <= `BPS_ST_RST;
		end else begin
			status_r <= statusNxt;
		end
	end

	assign irq = |(status_r & mask_r);

	bps_freq_div u_freq_div (
		.core_clk(core_clk),
		.rst     (rst),
		.oscLevel(oscSync),
		.oscTick (oscTick),
		.freqSel (ctrl_r[`BPS_CTRL_FSEL_HI:`BPS_CTRL_FSEL_LO]),
		.freqOut (freqWave)
	);

	assign pin1Low = pin1FreqSel ? (freqActive & ~freqWave) : (status_r[`BPS_ST_ALARM] & alarmActive);

	always @* begin
		pin2Assert = 1'b0;
		case (pin2Src)
			`BPS_PIN2_OFF:   pin2Assert = 1'b0;
			`BPS_PIN2_ALARM: pin2Assert = status_r[`BPS_ST_ALARM] & alarmActive;
			`BPS_PIN2_TIMER: pin2Assert = status_r[`BPS_ST_TIMER];
			`BPS_PIN2_BOTH:  pin2Assert = (status_r[`BPS_ST_ALARM] & alarmActive) | status_r[`BPS_ST_TIMER];
			default:         pin2Assert = 1'b0;
		endcase
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irqFreqOutPinOe <= 1'b0;
			secondIrqPinOe  <= 1'b0;
		end else begin
			irqFreqOutPinOe <= pin1Low;
			secondIrqPinOe  <= pin2Assert;
		end
	end

	assign irqFreqOutPinOut = 1'b0;
	assign secondIrqPinOut  = 1'b0;
endmodule

//--- bps_map.vh
// Register offsets, field positions, reset values and timing counts of the backup power switchover block.
`ifndef BPS_MAP_VH
`define BPS_MAP_VH

// Byte offsets of the register words on the Avalon-MM slave.
`define BPS_ADDR_W           4
`define BPS_OFS_CTRL         4'h0
`define BPS_OFS_STATUS       4'h4
`define BPS_OFS_MASK         4'h8
`define BPS_OFS_STATE        4'hC

// Control register fields.
`define BPS_CTRL_LOWPWR      0
`define BPS_CTRL_PIN1FUNC    1
`define BPS_CTRL_PIN2SRC_LO  2
`define BPS_CTRL_PIN2SRC_HI  3
`define BPS_CTRL_FSEL_LO     4
`define BPS_CTRL_FSEL_HI     5
`define BPS_CTRL_FOFFBAK     6
`define BPS_CTRL_AOFFBAK     7
`define BPS_CTRL_W           8
`define BPS_CTRL_RST         8'h00

// Status register fields; bits 0 to 3 are sticky and cleared by writing one.
`define BPS_ST_CLKFAIL       0
`define BPS_ST_BACKUP        1
`define BPS_ST_ALARM         2
`define BPS_ST_TIMER         3
`define BPS_ST_SEAL          4
`define BPS_ST_W             4
`define BPS_ST_RST           4'h0
`define BPS_MASK_RST         4'h0

// State register fields, read only.
`define BPS_STATE_BACKUP     0
`define BPS_STATE_SEALED     1
`define BPS_STATE_ARMED      2
`define BPS_STATE_SERIAL     3

// Second pin source encodings.
`define BPS_PIN2_OFF         2'h0
`define BPS_PIN2_ALARM       2'h1
`define BPS_PIN2_TIMER       2'h2
`define BPS_PIN2_BOTH        2'h3

// Frequency output selections and timebase divider taps.
`define BPS_FSEL_32K         2'h0
`define BPS_FSEL_8K          2'h1
`define BPS_FSEL_4K          2'h2
`define BPS_FSEL_1K          2'h3
`define BPS_DIV_W            5
`define BPS_TAP_8K           1
`define BPS_TAP_4K           2
`define BPS_TAP_1K           4

// Nominal timebase and core rate.
`define BPS_TIMEBASE_HZ      32768
`define BPS_CORE_HZ          200000000

`endif

//--- bps_sync.v
// Two flip-flop synchroniser for a group of level inputs.
`timescale 1ns/1ps
module bps_sync #(
	parameter WIDTH = 1
) (
	core_clk,
	rst,
	asyncIn,
	syncOut
);
	input  wire             core_clk;
	input  wire             rst;
	input  wire [WIDTH-1:0] asyncIn;
	output wire [WIDTH-1:0] syncOut;

	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= asyncIn;
			sync_r <= meta_r;
		end
	end

	assign syncOut = sync_r;
endmodule

//--- bps_freq_div.v
// Timebase divider that forms the selectable frequency output.
`timescale 1ns/1ps
`include "bps_map.vh"
module bps_freq_div (
	core_clk,
	rst,
	oscLevel,
	oscTick,
	freqSel,
	freqOut
);
	input  wire       core_clk;
	input  wire       rst;
	input  wire       oscLevel;
	input  wire       oscTick;
	input  wire [1:0] freqSel;
	output reg        freqOut;

	reg [`BPS_DIV_W-1:0] divCnt_r;
	reg                  freqNxt;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			divCnt_r <= {`BPS_DIV_W{1'b0}};
		end else if (oscTick) begin
			divCnt_r <= divCnt_r + {{(`BPS_DIV_W-1){1'b0}}, 1'b1};
		end
	end

	always @* begin
		freqNxt = oscLevel;
		case (freqSel)
			`BPS_FSEL_32K: freqNxt = oscLevel;
			`BPS_FSEL_8K:  freqNxt = divCnt_r[`BPS_TAP_8K];
			`BPS_FSEL_4K:  freqNxt = divCnt_r[`BPS_TAP_4K];
			`BPS_FSEL_1K:  freqNxt = divCnt_r[`BPS_TAP_1K];
			default:       freqNxt = oscLevel;
		endcase
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			freqOut <= 1'b0;
		end else begin
			freqOut <= freqNxt;
		end
	end
endmodule

//--- bps_checker.sv
// Port-level assertions for the backup power switchover block.
`timescale 1ns/1ps
module bps_checker (
	input wire core_clk,
	input wire rst,
	input wire oscInputPin,
	input wire cmpBelowBackup,
	input wire cmpAboveBackup,
	input wire cmpAboveTripHys,
	input wire sclIn,
	input wire sdaDriveLow,
	input wire sclGated,
	input wire sdaOut,
	input wire sdaOe,
	input wire backupSel,
	input wire backupDrawEn,
	input wire irqFreqOutPinOut,
	input wire secondIrqPinOut
);
	logic [7:0] sinceRise_r;
	logic       oscPrev_r;

	// Counts core cycles since the last raw timebase rising edge, saturating.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sinceRise_r <= 8'hFF;
			oscPrev_r <= 1'b0;
		end else begin
			oscPrev_r <= oscInputPin;
			if (oscInputPin && !oscPrev_r)
				sinceRise_r <= 8'h00;
			else if (sinceRise_r != 8'hFF)
				sinceRise_r <= sinceRise_r + 8'h01;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	serial_gate_a: assert property (backupSel && $past(backupSel) |-> !sclGated && !sdaOe)
		else $error("serial port active in backup");
	serial_pass_a: assert property (!$past(rst, 2) && !$past(backupSel, 2) && !$past(backupSel) && !backupSel
		|-> $past(sclGated) == $past(sclIn, 2) && $past(sdaOe) == $past(sdaDriveLow, 2))
		else $error("serial port not following inputs on main");
	pin_drive_a: assert property (!sdaOut && !irqFreqOutPinOut && !secondIrqPinOut)
		else $error("open drain pin driven high");
	seal_block_a: assert property (!backupDrawEn && !$past(backupDrawEn) |-> !$rose(backupSel))
		else $error("backup entered while sealed");
	unseal_cause_a: assert property ($rose(backupDrawEn) |-> cmpAboveBackup || cmpAboveTripHys)
		else $error("unsealed without main supply");
	entry_cause_a: assert property ($rose(backupSel) |-> cmpBelowBackup)
		else $error("backup entered with main above backup");
	exit_cause_a: assert property ($fell(backupSel) |-> cmpAboveBackup || cmpAboveTripHys)
		else $error("backup left without exit condition");
	tick_sync_a: assert property ($changed(backupSel) |-> sinceRise_r <= 8'h0C)
		else $error("supply mode changed away from a timebase tick");
endmodule

//--- bps_supply_model.sv
// Far-side model: supply comparators, timebase source and pin pull-ups.
`timescale 1ns/1ps
module bps_supply_model #(
	parameter OSC_HALF = 40,
	parameter HYS_BAK  = 50,
	parameter TRIP     = 2200,
	parameter HYS_TRIP = 30
) (
	input  wire        core_clk,
	input  wire [15:0] mainMv,
	input  wire [15:0] bakMv,
	input  wire        pin1Oe,
	input  wire        pin2Oe,
	output wire        cmpBelowBackup,
	output wire        cmpAboveBackup,
	output wire        cmpBelowTrip,
	output wire        cmpAboveTripHys,
	output logic       oscInputPin,
	output wire        pin1Level,
	output wire        pin2Level
);
	int cnt = 0;

	assign cmpBelowBackup = (mainMv + HYS_BAK) < bakMv;
	assign cmpAboveBackup = mainMv > (bakMv + HYS_BAK);
	assign cmpBelowTrip = mainMv < TRIP;
	assign cmpAboveTripHys = mainMv > (TRIP + HYS_TRIP);
	assign pin1Level = !pin1Oe;
	assign pin2Level = !pin2Oe;

	// External square wave
	// Runs faster than nominal so a supply change settles in a few hundred cycles.
	initial oscInputPin = 1'b0;
	always @(posedge core_clk) begin
		cnt <= (cnt == OSC_HALF - 1) ? 0 : cnt + 1;
		if (cnt == OSC_HALF - 1)
			oscInputPin <= !oscInputPin;
	end
endmodule

//--- tb_bps_backup_power_switchover.sv
// Self-checking bench for the backup power switchover block.
`timescale 1ns/1ps
`include "bps_map.vh"
module tb_bps_backup_power_switchover;
	localparam TICK = 80;
	logic        core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic        avs_waitrequest, oscInputPin, cmpBelowBackup, cmpAboveBackup, cmpBelowTrip, cmpAboveTripHys;
	logic        totalLossPowerUp = 1'b0, alarmEvent = 1'b0, timerEvent = 1'b0, sclIn = 1'b1, sdaDriveLow = 1'b1;
	logic        sclGated, sdaOut, sdaOe, backupSel, backupDrawEn, tripMonitorEn, irq, pin1Level, pin2Level;
	logic        irqFreqOutPinOut, irqFreqOutPinOe, secondIrqPinOut, secondIrqPinOe;
	logic [15:0] mainMv = 16'h03E8, bakMv = 16'h0BB8;
	int          n_fail = 0, compares = 0, cycles = 0;

	bps_backup_power_switchover uut (
		.core_clk        (core_clk),
		.rst             (rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.oscInputPin     (oscInputPin),
		.cmpBelowBackup  (cmpBelowBackup),
		.cmpAboveBackup  (cmpAboveBackup),
		.cmpBelowTrip    (cmpBelowTrip),
		.cmpAboveTripHys (cmpAboveTripHys),
		.totalLossPowerUp(totalLossPowerUp),
		.alarmEvent      (alarmEvent),
		.timerEvent      (timerEvent),
		.sclIn           (sclIn),
		.sdaDriveLow     (sdaDriveLow),
		.sclGated        (sclGated),
		.sdaOut          (sdaOut),
		.sdaOe           (sdaOe),
		.backupSel       (backupSel),
		.backupDrawEn    (backupDrawEn),
		.tripMonitorEn   (tripMonitorEn),
		.irqFreqOutPinOut(irqFreqOutPinOut),
		.irqFreqOutPinOe (irqFreqOutPinOe),
		.secondIrqPinOut (secondIrqPinOut),
		.secondIrqPinOe  (secondIrqPinOe),
		.irq             (irq)
	);
	bps_supply_model #(.OSC_HALF(TICK / 2)) far (.core_clk(core_clk), .mainMv(mainMv), .bakMv(bakMv),
		.pin1Oe(irqFreqOutPinOe), .pin2Oe(secondIrqPinOe), .cmpBelowBackup(cmpBelowBackup),
		.cmpAboveBackup(cmpAboveBackup), .cmpBelowTrip(cmpBelowTrip), .cmpAboveTripHys(cmpAboveTripHys),
		.oscInputPin(oscInputPin), .pin1Level(pin1Level), .pin2Level(pin2Level));

	initial forever #2.5 core_clk = ~core_clk;

	task finish_test;
		begin
			$display("compares %0d mismatches %0d", compares, n_fail);
			if (n_fail == 0 && compares > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 12000) begin
			n_fail++;
			finish_test;
		end
	end

	// Holds the request until waitrequest is sampled low, then releases it.
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		begin
			@(posedge core_clk);
			avs_address <= a;
			avs_write <= w;
			avs_read <= !w;
			avs_writedata <= d;
			do begin
				@(posedge core_clk);
			end while (avs_waitrequest !== 1'b0);
			q = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task rd(input logic [3:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			compares++;
			if (g !== e) begin
				n_fail++;
				$display("BAD %s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	task chkb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask

	// Waits three timebase periods so the synchronised supply state can settle.
	task sup(input logic [15:0] m, input logic [15:0] b);
		begin
			@(posedge core_clk);
			mainMv <= m;
			bakMv <= b;
			repeat (3 * TICK) @(posedge core_clk);
		end
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rd(`BPS_OFS_CTRL);
		chk("ctrl", 32'h0, q);
		rd(`BPS_OFS_STATUS);
		chk("status", 32'h10, q);
		rd(4'h2);
		chk("unmapped", 32'h0, q);
		sup(16'h03E8, 16'h0BB8);
		chkb("backupSel", 1'b0, backupSel);
		chkb("backupDrawEn", 1'b0, backupDrawEn);
		sup(16'h0CE4, 16'h0BB8);
		chkb("backupDrawEn", 1'b1, backupDrawEn);
		sup(16'h09C4, 16'h0BB8);
		chkb("backupSel", 1'b0, backupSel);
		chkb("sclGated", 1'b1, sclGated);
		chkb("sdaOe", 1'b1, sdaOe);
		sclIn <= 1'b0;
		sdaDriveLow <= 1'b0;
		repeat (2) @(posedge core_clk);
		chkb("sclGated", 1'b0, sclGated);
		chkb("sdaOe", 1'b0, sdaOe);
		sclIn <= 1'b1;
		sdaDriveLow <= 1'b1;
		sup(16'h07D0, 16'h0BB8);
		chkb("backupSel", 1'b1, backupSel);
		chkb("sclGated", 1'b0, sclGated);
		chkb("sdaOe", 1'b0, sdaOe);
		rd(`BPS_OFS_STATE);
		chk("state", 32'h1, q & 32'h9);
		rd(`BPS_OFS_STATUS);
		chk("status", 32'h2, q & 32'h2);
		sup(16'h08CA, 16'h0BB8);
		chkb("backupSel", 1'b0, backupSel);
		sup(16'h07D0, 16'h0BB8);
		sup(16'h07D0, 16'h0708);
		chkb("backupSel", 1'b0, backupSel);
		wr(`BPS_OFS_CTRL, 32'h1);
		repeat (4) @(posedge core_clk);
		chkb("tripMonitorEn", 1'b0, tripMonitorEn);
		sup(16'h0B54, 16'h0BB8);
		chkb("backupSel", 1'b1, backupSel);
		sup(16'h0C1C, 16'h0BB8);
		chkb("backupSel", 1'b0, backupSel);
		wr(`BPS_OFS_CTRL, 32'h2);
		@(posedge oscInputPin);
		repeat (6) @(posedge core_clk);
		chkb("pin1Level", 1'b1, pin1Level);
		repeat (TICK / 2) @(posedge core_clk);
		chkb("pin1Level", 1'b0, pin1Level);
		wr(`BPS_OFS_STATUS, 32'hF);
		wr(`BPS_OFS_MASK, 32'hC);
		wr(`BPS_OFS_CTRL, 32'h4);
		@(posedge core_clk);
		alarmEvent <= 1'b1;
		@(posedge core_clk);
		alarmEvent <= 1'b0;
		rd(`BPS_OFS_STATUS);
		chk("status", 32'h4, q & 32'hC);
		chkb("irq", 1'b1, irq);
		chkb("pin2Level", 1'b0, pin2Level);
		chkb("irqFreqOutPinOe", 1'b1, irqFreqOutPinOe);
		wr(`BPS_OFS_MASK, 32'h0);
		@(posedge core_clk);
		chkb("irq", 1'b0, irq);
		wr(`BPS_OFS_MASK, 32'hC);
		wr(`BPS_OFS_STATUS, 32'h4);
		repeat (2) @(posedge core_clk);
		chkb("irq", 1'b0, irq);
		chkb("pin2Level", 1'b1, pin2Level);
		wr(`BPS_OFS_CTRL, 32'h8);
		@(posedge core_clk);
		timerEvent <= 1'b1;
		@(posedge core_clk);
		timerEvent <= 1'b0;
		rd(`BPS_OFS_STATUS);
		chk("status", 32'h8, q & 32'hC);
		chkb("pin2Level", 1'b0, pin2Level);
		wr(`BPS_OFS_STATUS, 32'h8);
		alarmEvent <= 1'b1;
		@(posedge core_clk);
		alarmEvent <= 1'b0;
		repeat (3) @(posedge core_clk);
		chkb("pin2Level", 1'b1, pin2Level);
		totalLossPowerUp <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(`BPS_OFS_STATUS);
		chk("status", 32'h1, q & 32'h1);
		wr(`BPS_OFS_STATUS, 32'h10);
		rd(`BPS_OFS_STATE);
		chk("state", 32'h2, q & 32'h2);
		chkb("backupDrawEn", 1'b0, backupDrawEn);
		sup(16'h07D0, 16'h0BB8);
		chkb("backupSel", 1'b0, backupSel);
		sup(16'h0CE4, 16'h0BB8);
		chkb("backupDrawEn", 1'b1, backupDrawEn);
		finish_test;
	end
endmodule

bind bps_backup_power_switchover bps_checker chk_i (
	.core_clk        (core_clk),
	.rst             (rst),
	.oscInputPin     (oscInputPin),
	.cmpBelowBackup  (cmpBelowBackup),
	.cmpAboveBackup  (cmpAboveBackup),
	.cmpAboveTripHys (cmpAboveTripHys),
	.sclIn           (sclIn),
	.sdaDriveLow     (sdaDriveLow),
	.sclGated        (sclGated),
	.sdaOut          (sdaOut),
	.sdaOe           (sdaOe),
	.backupSel       (backupSel),
	.backupDrawEn    (backupDrawEn),
	.irqFreqOutPinOut(irqFreqOutPinOut),
	.secondIrqPinOut (secondIrqPinOut)
);
